// File: rtl/brf_pkg.sv
// package: constants and types of the block ram with fifo mode
package brf_pkg;
	localparam int BRF_ADDR_W = 10;
	localparam int BRF_DATA_W = 16;
	localparam logic [4:0] BRF_OFS_CTRL = 5'h00;
	localparam logic [4:0] BRF_OFS_FULL = 5'h04;
	localparam logic [4:0] BRF_OFS_AFULL = 5'h08;
	localparam logic [4:0] BRF_OFS_AEMPTY = 5'h0C;
	localparam logic [4:0] BRF_OFS_STATUS = 5'h10;
	localparam int BRF_CTRL_W = 6;
	localparam int BRF_CTRL_MODE_A = 0;
	localparam int BRF_CTRL_MODE_B = 2;
	localparam int BRF_CTRL_FIFO = 4;
	localparam int BRF_CTRL_ASYNC = 5;
	localparam int BRF_ST_EMPTY = 0;
	localparam int BRF_ST_AEMPTY = 1;
	localparam int BRF_ST_AFULL = 2;
	localparam int BRF_ST_FULL = 3;
	localparam int BRF_ST_COUNT = 16;
	localparam logic [5:0] BRF_CTRL_RST = 6'h00;
	localparam logic [15:0] BRF_FULL_RST = 16'hFFFF;
	localparam logic [15:0] BRF_AFULL_RST = 16'h0002;
	localparam logic [15:0] BRF_AEMPTY_RST = 16'h0002;
	localparam logic [2:0] BRF_SEL_MATCH = 3'h7;
	typedef enum logic [1:0] {
		BRF_WM_NORMAL = 2'h0,
		BRF_WM_THROUGH = 2'h1,
		BRF_WM_RBW = 2'h2
	} brf_wmode_t;
	typedef enum logic [1:0] {
		BRF_BUS_IDLE = 2'h0,
		BRF_BUS_ACK = 2'h1
	} brf_bus_t;
	function automatic logic [31:0] brf_be_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
		end
		return r;
	endfunction : brf_be_merge
endpackage : brf_pkg

// File: rtl/brf_port_if.sv
// interface: one ram port between the array and its output latch
`timescale 1ns/100ps
`default_nettype none
interface brf_port_if #(parameter int DW = 16);
	logic act;
	logic we;
	logic output_clock_enable;
	logic rst_local;
	logic [DW-1:0] wdata;
	logic [DW-1:0] old;
	logic [DW-1:0] rdata;
	modport top (output act, we, output_clock_enable, rst_local, wdata, old, input rdata);
	modport port (input act, we, output_clock_enable, rst_local, wdata, old, output rdata);
endinterface : brf_port_if
`default_nettype wire

// File: rtl/brf_port.sv
// module: output latch of one ram port with its write mode and resets
`timescale 1ns/100ps
`default_nettype none
module brf_port import brf_pkg::*; #(
	parameter int DW = BRF_DATA_W
) (
	// clock and resets
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic i_gsr,
	input wire logic i_async,
	// configuration
	input wire brf_wmode_t i_mode,
	// port
	brf_port_if.port p
);
	logic [DW-1:0] rdata_q;
	logic [DW-1:0] rdata_d;
	wire clr_w = p.rst_local | i_gsr; // [RL13] [RL14]
	// the async path gates the reset tree; glitch-free reset drivers needed
	wire arst_n = i_rstn & ~(i_async & clr_w); // [RL12]

	assign rdata_d = !p.we ? p.old : // [RL1]
		(i_mode == BRF_WM_THROUGH) ? p.wdata : // [RL2]
		(i_mode == BRF_WM_RBW) ? p.old : rdata_q; // [RL3]
	assign p.rdata = rdata_q;

	always_ff @(posedge i_clock or negedge arst_n) begin
		if (!arst_n) rdata_q <= '0;
		else if (clr_w) rdata_q <= '0; // [RL12]
		else if (p.act && p.output_clock_enable) rdata_q <= rdata_d;
	end

	a_normal_write_hold: assert property (@(posedge i_clock) disable iff (!i_rstn)
		p.act && p.output_clock_enable && p.we && i_mode == BRF_WM_NORMAL && !clr_w
		|=> $stable(rdata_q)) else $error("normal write changed output"); // [RL1]
	a_through_copy: assert property (@(posedge i_clock) disable iff (!i_rstn)
		p.act && p.output_clock_enable && p.we && i_mode == BRF_WM_THROUGH && !clr_w
		|=> rdata_q == $past(p.wdata)) else $error("no write-through copy"); // [RL2]
	a_rbw_old_word: assert property (@(posedge i_clock) disable iff (!i_rstn)
		p.act && p.output_clock_enable && p.we && i_mode == BRF_WM_RBW && !clr_w
		|=> rdata_q == $past(p.old)) else $error("old word not shown"); // [RL3]
	a_local_clear: assert property (@(posedge i_clock) disable iff (!i_rstn)
		p.rst_local |=> rdata_q == '0) else $error("local reset missed"); // [RL13]
	a_async_clear: assert property (@(posedge i_clock) disable iff (!i_rstn)
		i_async && clr_w |-> rdata_q == '0) else $error("async clear late"); // [RL12]
endmodule : brf_port
`default_nettype wire

// File: rtl/brf_flags.sv
// module: fifo pointers, entry count and the four registered flags
`timescale 1ns/100ps
`default_nettype none
module brf_flags import brf_pkg::*; #(
	parameter int AW = BRF_ADDR_W
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rstn,
	// requests
	input wire logic i_fifo_reset,
	input wire logic i_read_pointer_reset,
	input wire logic i_wr_req,
	input wire logic i_rd_req,
	// thresholds
	input wire logic [AW-1:0] i_full_thr,
	input wire logic [AW-1:0] i_afull_thr,
	input wire logic [AW-1:0] i_aempty_thr,
	// state
	output logic o_wr_fire,
	output logic o_rd_fire,
	output logic [AW-1:0] o_wptr,
	output logic [AW-1:0] o_rptr,
	output logic [AW:0] o_count,
	output logic o_full_flag,
	output logic o_almost_full_flag,
	output logic o_almost_empty_flag,
	output logic o_empty_flag
);
	logic [AW-1:0] wptr_q, rptr_q, wptr_d, rptr_d;
	logic [AW:0] count_q, count_d;
	logic full_q, afull_q, aempty_q, empty_q;

	assign o_wr_fire = i_wr_req & ~full_q & ~i_fifo_reset; // [RL17]
	assign o_rd_fire = i_rd_req & ~empty_q & ~i_fifo_reset; // [RL17]
	assign wptr_d = i_fifo_reset ? '0 : wptr_q + AW'(o_wr_fire); // [RL9]
	assign rptr_d = (i_fifo_reset || i_read_pointer_reset) ? '0 : // [RL10]
		rptr_q + AW'(o_rd_fire);
	// replay assumes the write pointer has not wrapped since the last reset
	assign count_d = i_fifo_reset ? '0 :
		i_read_pointer_reset ? {1'b0, wptr_d} : // [RL10]
		count_q + (AW+1)'(o_wr_fire) - (AW+1)'(o_rd_fire);

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			wptr_q <= '0;
			rptr_q <= '0;
			count_q <= '0;
			full_q <= 1'b0;
			afull_q <= 1'b0;
			aempty_q <= 1'b1;
			empty_q <= 1'b1;
		end else begin
			wptr_q <= wptr_d;
			rptr_q <= rptr_d;
			count_q <= count_d;
			full_q <= count_d >= {1'b0, i_full_thr}; // [RL5] [RL17]
			afull_q <= count_d >= {1'b0, i_afull_thr}; // [RL5] [RL17]
			aempty_q <= count_d <= {1'b0, i_aempty_thr}; // [RL6] [RL17]
			empty_q <= count_d == '0; // [RL6] [RL8]
		end
	end
	assign o_wptr = wptr_q;
	assign o_rptr = rptr_q;
	assign o_count = count_q;
	assign o_full_flag = full_q;
	assign o_almost_full_flag = afull_q;
	assign o_almost_empty_flag = aempty_q;
	assign o_empty_flag = empty_q;

	a_fifo_reset_all: assert property (@(posedge i_clock) disable iff (!i_rstn)
		i_fifo_reset |=> wptr_q == '0 && rptr_q == '0 && empty_q && aempty_q
		&& !full_q && !afull_q) else $error("fifo reset incomplete"); // [RL9]
	a_rptr_only: assert property (@(posedge i_clock) disable iff (!i_rstn)
		i_read_pointer_reset && !i_fifo_reset && !o_wr_fire
		|=> rptr_q == '0 && wptr_q == $past(wptr_q))
		else $error("read pointer reset moved write side"); // [RL10]
	a_afull_match: assert property (@(posedge i_clock) disable iff (!i_rstn)
		##1 afull_q == (count_q >= {1'b0, $past(i_afull_thr)}))
		else $error("almost full flag wrong"); // [RL5]
	a_aempty_match: assert property (@(posedge i_clock) disable iff (!i_rstn)
		aempty_q == (count_q <= {1'b0, $past(i_aempty_thr)}))
		else $error("almost empty flag wrong"); // [RL6]
	a_empty_match: assert property (@(posedge i_clock) disable iff (!i_rstn)
		empty_q == (count_q == '0)) else $error("empty flag wrong"); // [RL6]
	a_full_blocks: assert property (@(posedge i_clock) disable iff (!i_rstn)
		full_q && !i_fifo_reset && !i_read_pointer_reset && !o_rd_fire
		|=> count_q == $past(count_q)) else $error("write past full"); // [RL17]
endmodule : brf_flags
`default_nettype wire

// File: rtl/brf_top.sv
// top: block ram with selectable write modes and a fifo mode
//
// How it works
// [RL1] normal mode: a write leaves the port output unchanged.
// [RL2] write-through mode: a written word appears on the same port output.
// [RL3] read-before-write mode: a write shows the old word at that address.
// [RL4] fifo mode has independent write and read sides with enables.
// [RL5] full and almost-full flags are registers of the write side.
// [RL6] empty and almost-empty flags are registers of the read side.
// [RL7] full threshold ranges from one to two to the address width minus one.
// [RL8] almost thresholds range from one to full minus one; empty is zero.
// [RL9] fifo reset clears both pointers and puts all flags to reset state.
// [RL10] read pointer reset rewinds only the read pointer for replay.
// [RL11] user logic tracks packet timing so replay repeats the right data.
// [RL12] output latches reset synchronously or asynchronously, as configured.
// [RL13] each local port reset clears only its own output latch.
// [RL14] the global set/reset clears both port output latches.
// [RL15] full and empty inputs act as the third chip select bit.
// [RL16] all controls are active high, sampled on the rising clock edge; here i_global_set_reset_n is active low.
// [RL17] flags follow count against thresholds; full blocks writes, empty reads.
//
// one clock serves as write_clock and read_clock of the fifo.
`timescale 1ns/100ps
`default_nettype none
module brf_top import brf_pkg::*; #(
	parameter int ADDR_W = BRF_ADDR_W,
	parameter int DATA_W = BRF_DATA_W
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic i_global_set_reset_n,
	// avalon-mm slave
	input wire logic [4:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// ram port a
	input wire logic i_a_clock_enable,
	input wire logic i_a_output_clock_enable,
	input wire logic i_a_select,
	input wire logic i_a_write_enable,
	input wire logic [DATA_W/8-1:0] i_a_byte_enable,
	input wire logic [ADDR_W-1:0] i_a_addr,
	input wire logic [DATA_W-1:0] i_a_write_data,
	input wire logic i_port_a_output_reset,
	output logic [DATA_W-1:0] o_a_read_data,
	// ram port b
	input wire logic i_b_clock_enable,
	input wire logic i_b_output_clock_enable,
	input wire logic i_b_select,
	input wire logic i_b_write_enable,
	input wire logic [DATA_W/8-1:0] i_b_byte_enable,
	input wire logic [ADDR_W-1:0] i_b_addr,
	input wire logic [DATA_W-1:0] i_b_write_data,
	input wire logic i_port_b_output_reset,
	output logic [DATA_W-1:0] o_b_read_data,
	// fifo write side
	input wire logic i_write_clock_enable,
	input wire logic i_fifo_write_enable,
	input wire logic [1:0] i_write_port_select,
	input wire logic i_full_input,
	input wire logic [DATA_W-1:0] i_write_data,
	// fifo read side
	input wire logic i_read_clock_enable,
	input wire logic i_fifo_read_enable,
	input wire logic [1:0] i_read_port_select,
	input wire logic i_empty_input,
	input wire logic i_output_read_enable,
	output logic [DATA_W-1:0] o_fifo_read_data,
	// fifo resets and flags
	input wire logic i_fifo_reset,
	input wire logic i_read_pointer_reset,
	output logic o_full_flag,
	output logic o_almost_full_flag,
	output logic o_almost_empty_flag,
	output logic o_empty_flag
);
	localparam int DEPTH = 2 ** ADDR_W;
	localparam int BW = DATA_W / 8;

	if (ADDR_W < 2 || ADDR_W > 15 || DATA_W % 8 != 0 || DATA_W < 8)
	begin : g_bad_params
		$error("address width 2..15 and whole bytes of data only");
	end

	function automatic logic [DATA_W-1:0] lane_merge(
		input logic [DATA_W-1:0] old_v, input logic [DATA_W-1:0] new_v,
		input logic [BW-1:0] be);
		logic [DATA_W-1:0] r;
		r = old_v;
		for (int i = 0; i < BW; i++) begin
			if (be[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
		end
		return r;
	endfunction : lane_merge

	////////////////////////////////////////////////////////////////////////
	// registers over avalon-mm

	brf_bus_t bus_q, bus_d;
	logic wait_q;
	logic [31:0] rdata_q;
	logic [BRF_CTRL_W-1:0] ctrl_q;
	logic [ADDR_W-1:0] full_thr_q, afull_thr_q, aempty_thr_q;
	logic [31:0] rd_mux, wr_val;
	logic [ADDR_W:0] count_w;
	logic fl_full, fl_afull, fl_aempty, fl_empty;

	wire req_w = i_avs_read | i_avs_write;
	wire commit_w = (bus_q == BRF_BUS_ACK) & i_avs_write;
	wire fifo_mode = ctrl_q[BRF_CTRL_FIFO];
	wire async_rst = ctrl_q[BRF_CTRL_ASYNC];
	wire gsr_w = ~i_global_set_reset_n;

	assign rd_mux =
		(i_avs_address == BRF_OFS_CTRL) ? 32'(ctrl_q) :
		(i_avs_address == BRF_OFS_FULL) ? 32'(full_thr_q) :
		(i_avs_address == BRF_OFS_AFULL) ? 32'(afull_thr_q) :
		(i_avs_address == BRF_OFS_AEMPTY) ? 32'(aempty_thr_q) :
		(i_avs_address == BRF_OFS_STATUS) ?
		(32'(count_w) << BRF_ST_COUNT) |
		(32'(fl_full) << BRF_ST_FULL) | (32'(fl_afull) << BRF_ST_AFULL) |
		(32'(fl_aempty) << BRF_ST_AEMPTY) | (32'(fl_empty) << BRF_ST_EMPTY) :
		32'h0000_0000;

	// each register keeps its old value where the lane is not enabled
	assign wr_val = brf_be_merge(
		(i_avs_address == BRF_OFS_CTRL) ? 32'(ctrl_q) :
		(i_avs_address == BRF_OFS_FULL) ? 32'(full_thr_q) :
		(i_avs_address == BRF_OFS_AFULL) ? 32'(afull_thr_q) :
		32'(aempty_thr_q), i_avs_writedata, i_avs_byteenable);

	wire full_ok = wr_val >= 32'h1 && wr_val <= 32'(DEPTH - 1); // [RL7]
	wire almost_ok = wr_val >= 32'h1 && wr_val < 32'(full_thr_q); // [RL8]

	assign bus_d = (bus_q == BRF_BUS_IDLE && req_w) ? BRF_BUS_ACK :
		BRF_BUS_IDLE;

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			bus_q <= BRF_BUS_IDLE;
			wait_q <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end else begin
			bus_q <= bus_d;
			wait_q <= bus_d != BRF_BUS_ACK;
			if (bus_d == BRF_BUS_ACK) rdata_q <= rd_mux;
		end
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			ctrl_q <= BRF_CTRL_RST;
			full_thr_q <= BRF_FULL_RST[ADDR_W-1:0];
			afull_thr_q <= BRF_AFULL_RST[ADDR_W-1:0];
			aempty_thr_q <= BRF_AEMPTY_RST[ADDR_W-1:0];
		end else if (commit_w) begin
			case (i_avs_address)
				BRF_OFS_CTRL: ctrl_q <= wr_val[BRF_CTRL_W-1:0];
				BRF_OFS_FULL: if (full_ok) full_thr_q <= wr_val[ADDR_W-1:0];
				BRF_OFS_AFULL: if (almost_ok) afull_thr_q <= wr_val[ADDR_W-1:0];
				BRF_OFS_AEMPTY: if (almost_ok) aempty_thr_q <= wr_val[ADDR_W-1:0];
				default: ;
			endcase
		end
	end
	assign o_avs_waitrequest = wait_q;
	assign o_avs_readdata = rdata_q;

	////////////////////////////////////////////////////////////////////////
	// memory array and the two ram ports

	logic [DATA_W-1:0] mem_q [DEPTH];
	logic [1:0] ce_w, oce_w, sel_w, we_w, rst_w, act_w, wr_w;
	logic [BW-1:0] be_w [2];
	logic [ADDR_W-1:0] addr_w [2];
	logic [DATA_W-1:0] wdata_w [2];
	logic [DATA_W-1:0] rdata_w [2];
	brf_wmode_t mode_w [2];
	logic fifo_wr_req, fifo_rd_req, fifo_wr, fifo_rd;
	logic [ADDR_W-1:0] wptr_w, rptr_w;
	logic [DATA_W-1:0] fifo_rdata_q;

	assign ce_w = {i_b_clock_enable, i_a_clock_enable};
	assign oce_w = {i_b_output_clock_enable, i_a_output_clock_enable};
	assign sel_w = {i_b_select, i_a_select};
	assign we_w = {i_b_write_enable, i_a_write_enable};
	assign rst_w = {i_port_b_output_reset, i_port_a_output_reset};
	assign be_w[0] = i_a_byte_enable;
	assign be_w[1] = i_b_byte_enable;
	assign addr_w[0] = i_a_addr;
	assign addr_w[1] = i_b_addr;
	assign wdata_w[0] = i_a_write_data;
	assign wdata_w[1] = i_b_write_data;
	assign mode_w[0] = brf_wmode_t'(ctrl_q[BRF_CTRL_MODE_A +: 2]);
	assign mode_w[1] = brf_wmode_t'(ctrl_q[BRF_CTRL_MODE_B +: 2]);
	assign act_w = ce_w & sel_w & {2{~fifo_mode}}; // [RL16]
	assign wr_w = act_w & we_w;

	for (genvar g = 0; g < 2; g++) begin : g_port
		brf_port_if #(.DW(DATA_W)) pif ();
		assign pif.act = act_w[g];
		assign pif.we = we_w[g];
		assign pif.output_clock_enable = oce_w[g];
		assign pif.rst_local = rst_w[g]; // [RL13]
		assign pif.wdata = wdata_w[g];
		assign pif.old = mem_q[addr_w[g]];
		assign rdata_w[g] = pif.rdata;
		brf_port #(.DW(DATA_W)) u_port (
			.i_clock(i_clock),
			.i_rstn(i_rstn),
			.i_gsr(gsr_w), // [RL14]
			.i_async(async_rst), // [RL12]
			.i_mode(mode_w[g]),
			.p(pif.port)
		);
	end
	assign o_a_read_data = rdata_w[0];
	assign o_b_read_data = rdata_w[1];

	// port b wins when both ports write the same word in one cycle
	always_ff @(posedge i_clock) begin
		if (fifo_wr) mem_q[wptr_w] <= i_write_data;
		for (int k = 0; k < 2; k++) begin
			if (wr_w[k]) mem_q[addr_w[k]] <=
				lane_merge(mem_q[addr_w[k]], wdata_w[k], be_w[k]);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// fifo sides

	assign fifo_wr_req = fifo_mode & i_write_clock_enable & // [RL4]
		i_fifo_write_enable &
		({i_full_input, i_write_port_select} == BRF_SEL_MATCH); // [RL15]
	assign fifo_rd_req = fifo_mode & i_read_clock_enable & // [RL4]
		i_fifo_read_enable &
		({i_empty_input, i_read_port_select} == BRF_SEL_MATCH); // [RL15]

	brf_flags #(.AW(ADDR_W)) u_flags (
		.i_clock(i_clock),
		.i_rstn(i_rstn),
		.i_fifo_reset(i_fifo_reset), // [RL9]
		.i_read_pointer_reset(i_read_pointer_reset), // [RL10]
		.i_wr_req(fifo_wr_req),
		.i_rd_req(fifo_rd_req),
		.i_full_thr(full_thr_q),
		.i_afull_thr(afull_thr_q),
		.i_aempty_thr(aempty_thr_q),
		.o_wr_fire(fifo_wr),
		.o_rd_fire(fifo_rd),
		.o_wptr(wptr_w),
		.o_rptr(rptr_w),
		.o_count(count_w),
		.o_full_flag(fl_full),
		.o_almost_full_flag(fl_afull),
		.o_almost_empty_flag(fl_aempty),
		.o_empty_flag(fl_empty)
	);
	assign o_full_flag = fl_full;
	assign o_almost_full_flag = fl_afull;
	assign o_almost_empty_flag = fl_aempty;
	assign o_empty_flag = fl_empty;

	// a pop with the output read enable low is lost, as on the real latch
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) fifo_rdata_q <= '0;
		else if (fifo_rd && i_output_read_enable) // [RL4]
			fifo_rdata_q <= mem_q[rptr_w];
	end
	assign o_fifo_read_data = fifo_rdata_q;

	////////////////////////////////////////////////////////////////////////
	// checks

	a_sel_full_input: assert property (@(posedge i_clock) disable iff (!i_rstn)
		!i_full_input |-> !fifo_wr) else $error("write without full input"); // [RL15]
	a_sel_empty_input: assert property (@(posedge i_clock) disable iff (!i_rstn)
		!i_empty_input |-> !fifo_rd) else $error("read without empty input"); // [RL15]
	a_global_clear: assert property (@(posedge i_clock) disable iff (!i_rstn)
		gsr_w |=> o_a_read_data == '0 && o_b_read_data == '0)
		else $error("global reset missed a port"); // [RL14]
	a_full_thr_range: assert property (@(posedge i_clock) disable iff (!i_rstn)
		full_thr_q != '0) else $error("full threshold out of range"); // [RL7]
	a_bus_answer: assert property (@(posedge i_clock) disable iff (!i_rstn)
		bus_q == BRF_BUS_IDLE && req_w |=> !o_avs_waitrequest ##1
		o_avs_waitrequest) else $error("bus answer late"); // [RL16]
endmodule : brf_top
`default_nettype wire

// File: dv/brf_user_model.sv
// partner: user logic that streams numbered words into the fifo write side
`timescale 1ns/100ps
`default_nettype none
module brf_user_model import brf_pkg::*; (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rstn,
	// command from the bench
	input wire logic i_start,
	input wire logic i_slow,
	input wire logic [7:0] i_count,
	input wire logic [BRF_DATA_W-1:0] i_base,
	input wire logic i_blocked,
	// fifo write side
	output logic o_write_clock_enable,
	output logic o_fifo_write_enable,
	output logic [BRF_DATA_W-1:0] o_write_data,
	output logic o_done
);
	logic [7:0] left_q;
	logic take;
	// a word only counts as written if the block was free at that edge
	assign take = o_fifo_write_enable && !i_blocked;
	assign o_done = (left_q == 8'h00);
	// both enables rise together, active high, on the write clock
	assign o_write_clock_enable = o_fifo_write_enable;
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			left_q <= 8'h00;
			o_fifo_write_enable <= 1'b0;
			o_write_data <= '0;
		end else if (i_start) begin
			// one packet: count and first word known up front
			left_q <= i_count;
			o_write_data <= i_base;
			o_fifo_write_enable <= 1'b1;
		end else if (take) begin
			left_q <= left_q - 8'h01;
			o_write_data <= o_write_data + 1'b1;
			o_fifo_write_enable <= (left_q != 8'h01) && !i_slow;
		end else if (left_q != 8'h00) begin
			o_fifo_write_enable <= 1'b1;
		end else begin
			// idle data keeps moving so a stale word is never mistaken
			o_write_data <= ~o_write_data;
		end
	end
endmodule : brf_user_model
`default_nettype wire

// File: dv/tb_brf_top.sv
// testbench: ram write modes, output resets, registers and fifo mode
`timescale 1ns/100ps
`default_nettype none
module tb_brf_top import brf_pkg::*; ;
	logic i_clock = 1'b0, i_rstn = 1'b0, i_global_set_reset_n = 1'b1;
	logic [4:0] i_avs_address = 5'h00;
	logic i_avs_read = 1'b0, i_avs_write = 1'b0, o_avs_waitrequest;
	logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata;
	logic [3:0] i_avs_byteenable = 4'h0;
	logic i_a_clock_enable = 1'b0, i_a_select = 1'b0;
	logic i_a_write_enable = 1'b0, i_a_output_clock_enable = 1'b1;
	logic i_b_clock_enable = 1'b0, i_b_select = 1'b0;
	logic i_b_write_enable = 1'b0, i_b_output_clock_enable = 1'b1;
	logic [1:0] i_a_byte_enable = 2'h0, i_b_byte_enable = 2'h0;
	logic [9:0] i_a_addr = 10'h000, i_b_addr = 10'h000;
	logic [15:0] i_a_write_data = 16'h0, i_b_write_data = 16'h0;
	logic [15:0] o_a_read_data, o_b_read_data, o_fifo_read_data;
	logic i_port_a_output_reset = 1'b0, i_port_b_output_reset = 1'b0;
	logic i_write_clock_enable, i_fifo_write_enable;
	logic [15:0] i_write_data;
	logic [1:0] i_write_port_select = 2'h0, i_read_port_select = 2'h0;
	logic i_full_input = 1'b1, i_empty_input = 1'b1;
	logic i_read_clock_enable = 1'b0, i_fifo_read_enable = 1'b0;
	logic i_output_read_enable = 1'b0, i_fifo_reset = 1'b0;
	logic i_read_pointer_reset = 1'b0;
	logic o_full_flag, o_almost_full_flag, o_almost_empty_flag, o_empty_flag;
	logic u_start = 1'b0, u_done;
	logic [7:0] u_count = 8'h00;
	logic [15:0] u_base = 16'h0;
	int fails = 0;
	int checked = 0;

	brf_top dut (.*);
	brf_user_model user (.i_clock(i_clock), .i_rstn(i_rstn),
		.i_start(u_start), .i_slow(1'b0), .i_count(u_count), .i_base(u_base),
		.i_blocked(o_full_flag || !i_full_input),
		.o_write_clock_enable(i_write_clock_enable),
		.o_fifo_write_enable(i_fifo_write_enable),
		.o_write_data(i_write_data), .o_done(u_done));

	always #25 i_clock = ~i_clock;

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic finish_test();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : finish_test

	task automatic bus(input logic wr, input logic [4:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge i_clock);
		i_avs_address <= a;
		i_avs_writedata <= d;
		i_avs_byteenable <= 4'hF;
		i_avs_write <= wr;
		i_avs_read <= !wr;
		for (n = 0; n < 20; n++) begin
			@(posedge i_clock);
			#1;
			if (o_avs_waitrequest === 1'b0) break;
		end
		if (n == 20) begin
			fails++;
			finish_test();
		end
		// readdata is taken at the edge that sees waitrequest low
		@(posedge i_clock);
		q = o_avs_readdata;
		i_avs_write <= 1'b0;
		i_avs_read <= 1'b0;
	endtask : bus

	task automatic wreg(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wreg

	task automatic rreg(input logic [4:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk("register", exp, q);
	endtask : rreg

	task automatic ram_a(input logic we, input logic [9:0] a,
		input logic [15:0] d);
		@(posedge i_clock);
		i_a_clock_enable <= 1'b1;
		i_a_select <= 1'b1;
		i_a_byte_enable <= 2'h3;
		i_a_write_enable <= we;
		i_a_addr <= a;
		i_a_write_data <= d;
		@(posedge i_clock);
		i_a_clock_enable <= 1'b0;
		i_a_select <= 1'b0;
		#1;
	endtask : ram_a

	task automatic read_both();
		ram_a(1'b0, 10'h006, 16'h0);
		i_b_addr <= 10'h006;
		i_b_clock_enable <= 1'b1;
		i_b_select <= 1'b1;
		@(posedge i_clock);
		i_b_clock_enable <= 1'b0;
		i_b_select <= 1'b0;
		#1;
	endtask : read_both

	task automatic flags(input logic [3:0] exp);
		@(posedge i_clock);
		#1;
		chk("flags", exp, {o_full_flag, o_almost_full_flag,
			o_almost_empty_flag, o_empty_flag});
	endtask : flags

	task automatic fifo_rd(input logic [15:0] exp);
		@(posedge i_clock);
		i_read_clock_enable <= 1'b1;
		i_fifo_read_enable <= 1'b1;
		i_output_read_enable <= 1'b1;
		@(posedge i_clock);
		i_read_clock_enable <= 1'b0;
		i_fifo_read_enable <= 1'b0;
		@(posedge i_clock);
		#1;
		chk("fifo data", exp, o_fifo_read_data);
	endtask : fifo_rd

	task automatic push(input logic [7:0] n, input logic [15:0] b);
		@(posedge i_clock);
		u_count <= n;
		u_base <= b;
		u_start <= 1'b1;
		@(posedge i_clock);
		u_start <= 1'b0;
	endtask : push

	task automatic wait_for(ref logic s);
		int n;
		for (n = 0; n < 40 && s !== 1'b1; n++) @(posedge i_clock);
		#1;
		if (n == 40) begin
			fails++;
			finish_test();
		end
	endtask : wait_for

	////////////////////////////////////////////////////////////////////////
	task automatic t_registers();
		flags(4'h3);
		rreg(BRF_OFS_CTRL, 32'h0);
		rreg(BRF_OFS_FULL, 32'h3FF);
		rreg(BRF_OFS_AFULL, 32'h2);
		rreg(BRF_OFS_AEMPTY, 32'h2);
		rreg(5'h14, 32'h0);
		wreg(BRF_OFS_FULL, 32'h0);
		rreg(BRF_OFS_FULL, 32'h3FF);
		wreg(BRF_OFS_AFULL, 32'h3FF);
		rreg(BRF_OFS_AFULL, 32'h2);
		wreg(BRF_OFS_STATUS, 32'hFFFF);
		rreg(BRF_OFS_STATUS, 32'h3);
	endtask : t_registers

	task automatic t_write_modes();
		logic [15:0] old_v, exp;
		ram_a(1'b1, 10'h006, 16'h6666);
		for (int m = 0; m < 3; m++) begin
			old_v = 16'(16'h1111 * (m + 1));
			wreg(BRF_OFS_CTRL, 32'(m));
			ram_a(1'b1, 10'h005, old_v);
			ram_a(1'b0, 10'h006, 16'h0);
			chk("port a read", 16'h6666, o_a_read_data);
			ram_a(1'b1, 10'h005, 16'hA0A0 + 16'(m));
			exp = (m == 0) ? 16'h6666 : (m == 1) ? 16'hA0A1 : old_v;
			chk("port a write", exp, o_a_read_data);
		end
	endtask : t_write_modes

	task automatic t_out_resets();
		wreg(BRF_OFS_CTRL, 32'h0);
		read_both();
		i_port_a_output_reset <= 1'b1;
		@(posedge i_clock);
		i_port_a_output_reset <= 1'b0;
		@(posedge i_clock);
		#1;
		chk("port a out", 16'h0, o_a_read_data);
		chk("port b out", 16'h6666, o_b_read_data);
		read_both();
		i_global_set_reset_n <= 1'b0;
		@(posedge i_clock);
		i_global_set_reset_n <= 1'b1;
		@(posedge i_clock);
		#1;
		chk("global a", 16'h0, o_a_read_data);
		chk("global b", 16'h0, o_b_read_data);
		wreg(BRF_OFS_CTRL, 32'h20);
		read_both();
		i_port_b_output_reset <= 1'b1;
		#10;
		chk("async b", 16'h0, o_b_read_data);
		chk("async a", 16'h6666, o_a_read_data);
		@(posedge i_clock);
		i_port_b_output_reset <= 1'b0;
	endtask : t_out_resets

	task automatic t_port_b();
		wreg(BRF_OFS_CTRL, 32'h4);
		@(posedge i_clock);
		i_b_clock_enable <= 1'b1;
		i_b_select <= 1'b1;
		i_b_write_enable <= 1'b1;
		i_b_byte_enable <= 2'h1;
		i_b_addr <= 10'h006;
		i_b_write_data <= 16'h1234;
		@(posedge i_clock);
		i_b_write_enable <= 1'b0;
		#1;
		chk("port b through", 16'h1234, o_b_read_data);
		@(posedge i_clock);
		i_b_clock_enable <= 1'b0;
		i_b_select <= 1'b0;
		#1;
		chk("port b lanes", 16'h6634, o_b_read_data);
	endtask : t_port_b

	task automatic t_fifo();
		wreg(BRF_OFS_CTRL, 32'h10);
		wreg(BRF_OFS_FULL, 32'h4);
		wreg(BRF_OFS_AFULL, 32'h3);
		wreg(BRF_OFS_AEMPTY, 32'h1);
		i_write_port_select <= 2'h3;
		i_read_port_select <= 2'h3;
		push(8'h05, 16'h0100);
		wait_for(o_full_flag);
		flags(4'hC);
		fifo_rd(16'h0100);
		wait_for(u_done);
		for (int k = 1; k < 5; k++) fifo_rd(16'h0100 + 16'(k));
		flags(4'h3);
		fifo_rd(16'h0104);
		i_read_pointer_reset <= 1'b1;
		@(posedge i_clock);
		i_read_pointer_reset <= 1'b0;
		fifo_rd(16'h0100);
		rreg(BRF_OFS_STATUS, 32'h0004000C);
		i_fifo_reset <= 1'b1;
		@(posedge i_clock);
		i_fifo_reset <= 1'b0;
		flags(4'h3);
		rreg(BRF_OFS_STATUS, 32'h3);
		i_full_input <= 1'b0;
		push(8'h01, 16'h0200);
		flags(4'h3);
		i_full_input <= 1'b1;
		wait_for(u_done);
		i_empty_input <= 1'b0;
		fifo_rd(16'h0100);
		i_empty_input <= 1'b1;
		fifo_rd(16'h0200);
	endtask : t_fifo

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge i_clock);
		i_rstn <= 1'b1;
		t_registers();
		t_write_modes();
		t_out_resets();
		t_port_b();
		t_fifo();
		finish_test();
	end
endmodule : tb_brf_top
`default_nettype wire
